// ==== rtl/fnp_pkg.sv ====
// Purpose: constants for the fiber negotiation page register group
// Assumes: word-indexed register map, byte address is four times the index
// Notes:   shared by the register bank and its bench
package fnp_pkg;

  // ---------------------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [11:0] FNP_IDX_PARTNER_ABL = 12'hc05;
  localparam logic [11:0] FNP_IDX_NEG_EXP     = 12'hc06;
  localparam logic [11:0] FNP_IDX_LOCAL_NP    = 12'hc07;
  localparam logic [11:0] FNP_IDX_PARTNER_NP  = 12'hc08;
  localparam logic [11:0] FNP_IDX_FIBER_CFG0  = 12'hc10;
  localparam logic [11:0] FNP_IDX_IRQ_ENABLE  = 12'hc18;
  localparam logic [11:0] FNP_IDX_IRQ_STATUS  = 12'hc19;
  localparam int          FNP_ADDR_W          = 14;
  localparam int          FNP_IDX_LSB         = 2;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] FNP_RST_PARTNER_ABL = 16'h0000;
  localparam logic [15:0] FNP_RST_NEG_EXP     = 16'h0000;
  localparam logic [15:0] FNP_RST_LOCAL_NP    = 16'h2001;
  localparam logic [15:0] FNP_RST_PARTNER_NP  = 16'h0000;
  localparam logic [15:0] FNP_RST_FIBER_CFG0  = 16'h0000;
  localparam logic [15:0] FNP_RST_IRQ_ENABLE  = 16'h03ff;
  localparam logic [15:0] FNP_RST_IRQ_STATUS  = 16'h0000;

  // ---------------------------------------------------------------------------
  // field positions and masks
  // ---------------------------------------------------------------------------
  localparam logic [15:0] FNP_ABL_MASK        = 16'hf1e0; // bits 15,14,13:12,8:5
  localparam int          FNP_BIT_NP          = 15;
  localparam int          FNP_FAULT_HI        = 13;
  localparam int          FNP_FAULT_LO        = 12;
  localparam logic [15:0] FNP_PNP_MASK        = 16'hbfff; // bit 14 reserved
  localparam logic [15:0] FNP_LNP_WR_MASK     = 16'hb7ff; // 15,13,12,10:0
  localparam int          FNP_BIT_TOGGLE      = 11;
  localparam int          FNP_EXP_PNP_ABLE    = 3;
  localparam int          FNP_EXP_LNP_ABLE    = 2;
  localparam int          FNP_EXP_PAGE_RCVD   = 1;
  localparam int          FNP_EXP_NEG_ABLE    = 0;
  localparam int          FNP_CFG_SIGDET_BYP  = 9;
  localparam logic [15:0] FNP_CFG_WR_MASK     = 16'h0200;
  localparam logic [15:0] FNP_IRQ_MASK        = 16'h03ff;
  localparam int          FNP_IRQ_BASE_RX     = 0;
  localparam int          FNP_IRQ_NP_RX       = 1;
  localparam int          FNP_IRQ_FAULT_RX    = 3;
  localparam int          FNP_IRQ_W           = 10;

endpackage : fnp_pkg

// ==== rtl/fnp_regs.sv ====
// Purpose: fiber auto-negotiation page registers behind an APB slave
// Assumes: negotiation engine on clk hands over received pages as pulses
// Notes:   each APB access answers at the second access cycle
`timescale 1ns/1ps

module fnp_regs
  import fnp_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [FNP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // pages from the negotiation engine
  input  wire logic                  page_valid,
  input  wire logic                  page_is_base,
  input  wire logic [15:0]           page_word,
  input  wire logic                  neg_enable_state,
  input  wire logic                  sgmii_mode,
  input  wire logic                  np_codeword_sent,
  input  wire logic [FNP_IRQ_W-1:0]  other_irq_events,
  // signal detect
  input  wire logic                  sigdet_pin,
  output logic                       signal_present,
  // local next page toward the transmitter
  output logic      [15:0]           local_np_word
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [15:0] partner_abl_r;
  logic [15:0] exp_r;
  logic [15:0] local_np_r;
  logic [15:0] partner_np_r;
  logic [15:0] cfg0_r;
  logic [15:0] irq_en_r;
  logic [15:0] irq_sts_r;
  logic        sd_meta_r;
  logic        sd_sync_r;
  logic        sig_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  function automatic logic hit(input logic [FNP_ADDR_W-1:0] a, input logic [11:0] idx);
    hit = (a[FNP_ADDR_W-1:FNP_IDX_LSB] == idx) && (a[FNP_IDX_LSB-1:0] == '0);
  endfunction : hit

  wire logic access_done = psel & penable & pready_r;
  wire logic wr_done     = access_done & pwrite;
  // read data and read-clear share one edge, the one that raises pready;
  // clearing a cycle later would drop an event landing between the two
  wire logic rd_take     = psel & penable & ~pready_r & ~pwrite;
  wire logic sel_abl     = hit(paddr, FNP_IDX_PARTNER_ABL);
  wire logic sel_exp     = hit(paddr, FNP_IDX_NEG_EXP);
  wire logic sel_lnp     = hit(paddr, FNP_IDX_LOCAL_NP);
  wire logic sel_pnp     = hit(paddr, FNP_IDX_PARTNER_NP);
  wire logic sel_cfg     = hit(paddr, FNP_IDX_FIBER_CFG0);
  wire logic sel_ien     = hit(paddr, FNP_IDX_IRQ_ENABLE);
  wire logic sel_ist     = hit(paddr, FNP_IDX_IRQ_STATUS);
  wire logic mapped      = sel_abl | sel_exp | sel_lnp | sel_pnp | sel_cfg | sel_ien | sel_ist;

  // page events
  wire logic base_rx     = page_valid & page_is_base;
  wire logic np_rx       = page_valid & ~page_is_base;
  wire logic fault_rx    = base_rx & (page_word[FNP_FAULT_HI:FNP_FAULT_LO] != 2'b00);

  // local np able
  // expansion view: local next page ability is a live mode bit
  wire logic [15:0] exp_view = exp_r | ({15'h0000, ~sgmii_mode} << FNP_EXP_LNP_ABLE);

  // read mux
  wire logic [15:0] rd_word =
      ({16{sel_abl}} & partner_abl_r) |
      ({16{sel_exp}} & exp_view)      |
      ({16{sel_lnp}} & local_np_r)    |
      ({16{sel_pnp}} & partner_np_r)  |
      ({16{sel_cfg}} & cfg0_r)        |
      ({16{sel_ien}} & irq_en_r)      |
      ({16{sel_ist}} & irq_sts_r);

  // ---------------------------------------------------------------------------
  // apb answer: pready rises one cycle into the access phase
  // ---------------------------------------------------------------------------
  // one fixed wait state keeps the read mux off the pready path
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      prdata_r  <= rd_take ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // partner base page capture
  // ---------------------------------------------------------------------------
  // capture masked base page
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      partner_abl_r <= FNP_RST_PARTNER_ABL;
    end else if (base_rx) begin
      partner_abl_r <= page_word & FNP_ABL_MASK;
    end
  end

  // ---------------------------------------------------------------------------
  // expansion flags; a set in the clearing cycle wins
  // ---------------------------------------------------------------------------
  logic [15:0] exp_nxt;
  always_comb begin
    exp_nxt = exp_r;
    if (neg_enable_state) begin
      exp_nxt[FNP_EXP_PNP_ABLE] = 1'b0;
      exp_nxt[FNP_EXP_NEG_ABLE] = 1'b0;
    end
    // read of the expansion register clears page received
    if (rd_take && sel_exp) begin
      exp_nxt[FNP_EXP_PAGE_RCVD] = 1'b0;
    end
    // set on base page carrying next page; SGMII partners send zero
    if (base_rx && page_word[FNP_BIT_NP]) begin
      exp_nxt[FNP_EXP_PNP_ABLE] = 1'b1;
    end
    // any base page shows the partner negotiates
    if (base_rx) begin
      exp_nxt[FNP_EXP_NEG_ABLE] = 1'b1;
    end
    if (page_valid) begin
      exp_nxt[FNP_EXP_PAGE_RCVD] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exp_r <= FNP_RST_NEG_EXP;
    end else begin
      exp_r <= exp_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // local next page: writable fields, hardware toggle
  // ---------------------------------------------------------------------------
  logic [15:0] local_np_nxt;
  always_comb begin
    local_np_nxt = local_np_r;
    if (wr_done && sel_lnp) begin
      local_np_nxt = (pwdata[15:0] & FNP_LNP_WR_MASK) | (local_np_r & ~FNP_LNP_WR_MASK);
    end
    if (np_codeword_sent) begin
      local_np_nxt[FNP_BIT_TOGGLE] = ~local_np_r[FNP_BIT_TOGGLE];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      local_np_r <= FNP_RST_LOCAL_NP;
    end else begin
      local_np_r <= local_np_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // partner next page capture
  // ---------------------------------------------------------------------------
  // capture received next page
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      partner_np_r <= FNP_RST_PARTNER_NP;
    end else if (np_rx) begin
      partner_np_r <= page_word & FNP_PNP_MASK;
    end
  end

  // ---------------------------------------------------------------------------
  // config, interrupt enable and status
  // ---------------------------------------------------------------------------
  // only bit 9 of config is writable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg0_r   <= FNP_RST_FIBER_CFG0;
      irq_en_r <= FNP_RST_IRQ_ENABLE;
    end else if (wr_done) begin
      if (sel_cfg) begin
        cfg0_r <= pwdata[15:0] & FNP_CFG_WR_MASK;
      end
      if (sel_ien) begin
        irq_en_r <= pwdata[15:0] & FNP_IRQ_MASK;
      end
    end
  end

  // own page events join the other sources; disabled sources never pend
  logic [FNP_IRQ_W-1:0] irq_evt;
  always_comb begin
    irq_evt = other_irq_events;
    irq_evt[FNP_IRQ_BASE_RX]  = other_irq_events[FNP_IRQ_BASE_RX] | base_rx;
    irq_evt[FNP_IRQ_NP_RX]    = other_irq_events[FNP_IRQ_NP_RX] | np_rx;
    irq_evt[FNP_IRQ_FAULT_RX] = other_irq_events[FNP_IRQ_FAULT_RX] | fault_rx;
  end

  wire logic [15:0] irq_set = {{(16-FNP_IRQ_W){1'b0}}, irq_evt} & irq_en_r;

  // read clears, a new event in that cycle survives
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_sts_r <= FNP_RST_IRQ_STATUS;
    end else if (rd_take && sel_ist) begin
      irq_sts_r <= irq_set;
    end else begin
      irq_sts_r <= irq_sts_r | irq_set;
    end
  end

  // ---------------------------------------------------------------------------
  // signal detect pin: two-flop synchroniser, then the bypass
  // ---------------------------------------------------------------------------
  // pin changes reach signal_present three edges later; glitches shorter
  // than a clock period may be missed, which is acceptable for a level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sd_meta_r <= 1'b0;
      sd_sync_r <= 1'b0;
      sig_r     <= 1'b0;
    end else begin
      sd_meta_r <= sigdet_pin;
      sd_sync_r <= sd_meta_r;
      sig_r     <= cfg0_r[FNP_CFG_SIGDET_BYP] | sd_sync_r;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign signal_present = sig_r;
  assign local_np_word  = local_np_r;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_abl_capture: assert property (
    @(posedge clk) disable iff (!nrst)
    base_rx |=> partner_abl_r == ($past(page_word) & FNP_ABL_MASK))
    else $error("partner ability not captured from base page");

  a_exp_pnp_set: assert property (
    @(posedge clk) disable iff (!nrst)
    (base_rx && page_word[FNP_BIT_NP]) |=> exp_r[FNP_EXP_PNP_ABLE])
    else $error("partner next page able not set");

  a_exp_enable_clr: assert property (
    @(posedge clk) disable iff (!nrst)
    (neg_enable_state && !base_rx) |=> !exp_r[FNP_EXP_NEG_ABLE] && !exp_r[FNP_EXP_PNP_ABLE])
    else $error("enable state did not clear expansion flags");

  a_exp_local_np: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd_take && sel_exp) |=> prdata_r[FNP_EXP_LNP_ABLE] == !$past(sgmii_mode))
    else $error("local next page able does not follow mode");

  a_page_rcvd_rc: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd_take && sel_exp && !page_valid) |=> !exp_r[FNP_EXP_PAGE_RCVD])
    else $error("page received not cleared by read");

  a_toggle_flip: assert property (
    @(posedge clk) disable iff (!nrst)
    np_codeword_sent |=> local_np_r[FNP_BIT_TOGGLE] != $past(local_np_r[FNP_BIT_TOGGLE]))
    else $error("local toggle did not flip");

  a_pnp_capture: assert property (
    @(posedge clk) disable iff (!nrst)
    np_rx |=> partner_np_r == ($past(page_word) & FNP_PNP_MASK))
    else $error("partner next page not captured");

  a_sigdet_bypass: assert property (
    @(posedge clk) disable iff (!nrst)
    cfg0_r[FNP_CFG_SIGDET_BYP] |=> signal_present)
    else $error("bypass did not force signal present");

  a_irq_read_clr: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd_take && sel_ist && irq_set == 16'h0000) |=> irq_sts_r == 16'h0000)
    else $error("interrupt status not cleared by read");

  a_apb_answer: assert property (
    @(posedge clk) disable iff (!nrst)
    (psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
    else $error("apb answer not a single cycle after one wait");

  a_lnp_write: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_done && sel_lnp) |=> (local_np_r & FNP_LNP_WR_MASK) == ($past(pwdata[15:0]) & FNP_LNP_WR_MASK))
    else $error("local next page writable fields not written");

  // a pending source stays set even when a read clears in the same cycle
  a_irq_pend_set: assert property (
    @(posedge clk) disable iff (!nrst)
    (irq_set != 16'h0000) |=> (irq_sts_r & $past(irq_set)) == $past(irq_set))
    else $error("enabled interrupt event not pending");

  // refused accesses answer with an error and zero data
  a_slverr_unmapped: assert property (
    @(posedge clk) disable iff (!nrst)
    (psel && penable && !pready_r && !mapped) |=> pslverr_r && prdata_r == 32'h0000_0000)
    else $error("unmapped access not refused");

endmodule : fnp_regs

// ==== verif/fnp_page_source.sv ====
// Purpose: far-side model handing received pages to the register bank
// Assumes: pages arrive one per call, launched right after a rising edge
// Notes:   page_word shows the inverse of the last page while idle
`timescale 1ns/1ps

module fnp_page_source (
  // clock and mode
  input  wire logic        clk,
  input  wire logic        sgmii_mode,
  // page hand-over
  output logic             page_valid,
  output logic             page_is_base,
  output logic [15:0]      page_word,
  output logic             np_codeword_sent
);
  initial begin
    page_valid       = 1'b0;
    page_is_base     = 1'b0;
    page_word        = 16'h0000;
    np_codeword_sent = 1'b0;
  end

  // one page pulse, then the word goes stale on purpose
  task automatic send_page(input logic base, input logic [15:0] w);
    logic [15:0] v;
    v = w;
    if (base && sgmii_mode) v[15] = 1'b0;
    page_valid   <= 1'b1;
    page_is_base <= base;
    page_word    <= v;
    @(posedge clk);
    page_valid   <= 1'b0;
    page_word    <= ~v;
    @(posedge clk);
  endtask : send_page

  // one transmitted next-page codeword
  task automatic send_codeword();
    np_codeword_sent <= 1'b1;
    @(posedge clk);
    np_codeword_sent <= 1'b0;
    @(posedge clk);
  endtask : send_codeword
endmodule : fnp_page_source

// ==== verif/fiber_autoneg_page_registers_bench.sv ====
// Purpose: self-checking bench for the fiber page register bank
// Assumes: apb slave answers with pready, waited for under a limit
// Notes:   expectations come from the register map and field rules
`timescale 1ns/1ps

module fiber_autoneg_page_registers_bench;
  import fnp_pkg::*;
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [FNP_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, neg_enable_state = 1'b0, sgmii_mode = 1'b0, sigdet_pin = 1'b0;
  logic page_valid, page_is_base, np_codeword_sent, signal_present;
  logic [15:0] page_word, local_np_word, rd;
  logic [FNP_IRQ_W-1:0] other_irq_events = '0;
  logic err;
  int miscompares = 0, tests_run = 0, cycles = 0;

  always #2.5 clk = ~clk;

  fnp_page_source i_src (.clk(clk), .sgmii_mode(sgmii_mode), .page_valid(page_valid),
    .page_is_base(page_is_base), .page_word(page_word), .np_codeword_sent(np_codeword_sent));

  fnp_regs i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .page_valid(page_valid), .page_is_base(page_is_base), .page_word(page_word),
    .neg_enable_state(neg_enable_state), .sgmii_mode(sgmii_mode),
    .np_codeword_sent(np_codeword_sent), .other_irq_events(other_irq_events),
    .sigdet_pin(sigdet_pin), .signal_present(signal_present), .local_np_word(local_np_word));

  // ---------------------------------------------------------------------------
  // apb master: hold the request until pready, then one idle edge
  // ---------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] wd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: pready or the bench hang guard ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata[15:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // ---------------------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(0, FNP_IDX_PARTNER_ABL, 0); `CHK(rd, FNP_RST_PARTNER_ABL)
    apb(0, FNP_IDX_NEG_EXP, 0);     `CHK(rd, 16'h0004)
    apb(0, FNP_IDX_LOCAL_NP, 0);    `CHK(rd, 16'h2001)
    apb(0, FNP_IDX_PARTNER_NP, 0);  `CHK(rd, 16'h0000)
    apb(0, FNP_IDX_FIBER_CFG0, 0);  `CHK(rd, 16'h0000)
    apb(0, FNP_IDX_IRQ_ENABLE, 0);  `CHK(rd, 16'h03ff)
    apb(0, 12'h000, 0);             `CHK({err, rd}, 17'h10000)
    // every fault code, with next page, ack, pause and duplex bits
    for (int c = 0; c < 4; c++) begin
      i_src.send_page(1'b1, 16'hc1e0 | (c << 12) | 16'h0e1f);
      apb(0, FNP_IDX_PARTNER_ABL, 0); `CHK(rd, 16'hc1e0 | (c << 12))
    end
    apb(0, FNP_IDX_IRQ_STATUS, 0);  `CHK(rd, 16'h0009)
    apb(0, FNP_IDX_IRQ_STATUS, 0);  `CHK(rd, 16'h0000)
    apb(0, FNP_IDX_NEG_EXP, 0);     `CHK(rd, 16'h000f)
    apb(0, FNP_IDX_NEG_EXP, 0);     `CHK(rd, 16'h000d)
    neg_enable_state <= 1'b1;
    @(posedge clk);
    neg_enable_state <= 1'b0;
    @(posedge clk);
    apb(0, FNP_IDX_NEG_EXP, 0);     `CHK(rd, 16'h0004)
    sgmii_mode <= 1'b1;
    @(posedge clk);
    apb(0, FNP_IDX_NEG_EXP, 0);     `CHK(rd, 16'h0000)
    i_src.send_page(1'b1, 16'h81a0);
    apb(0, FNP_IDX_PARTNER_ABL, 0); `CHK(rd, 16'h01a0)
    apb(0, FNP_IDX_NEG_EXP, 0);     `CHK(rd, 16'h0003)
    sgmii_mode <= 1'b0;
    i_src.send_page(1'b0, 16'hf805);
    apb(0, FNP_IDX_PARTNER_NP, 0);  `CHK(rd, 16'hb805)
    apb(0, FNP_IDX_NEG_EXP, 0);     `CHK(rd, 16'h0007)
    apb(0, FNP_IDX_IRQ_STATUS, 0);  `CHK(rd, 16'h0003)
    // masked sources stay quiet, enabled ones latch until read
    apb(1, FNP_IDX_IRQ_ENABLE, 16'h0000);
    i_src.send_page(1'b1, 16'h3000);
    apb(0, FNP_IDX_IRQ_STATUS, 0);  `CHK(rd, 16'h0000)
    apb(1, FNP_IDX_IRQ_ENABLE, 16'hffff);
    apb(0, FNP_IDX_IRQ_ENABLE, 0);  `CHK(rd, 16'h03ff)
    other_irq_events <= 10'h3f6;
    @(posedge clk);
    other_irq_events <= '0;
    @(posedge clk);
    apb(0, FNP_IDX_IRQ_STATUS, 0);  `CHK(rd, 16'h03f6)
    apb(0, FNP_IDX_IRQ_STATUS, 0);  `CHK(rd, 16'h0000)
    // local next page: writable fields, toggle owned by the device
    apb(1, FNP_IDX_LOCAL_NP, 16'hffff);
    apb(0, FNP_IDX_LOCAL_NP, 0);    `CHK(rd, 16'hb7ff)
    i_src.send_codeword();
    apb(0, FNP_IDX_LOCAL_NP, 0);    `CHK(rd, 16'hbfff)
    `CHK(local_np_word, 16'hbfff)
    // signal detect bypass and the synchronised pin
    apb(1, FNP_IDX_FIBER_CFG0, 16'hffff);
    apb(0, FNP_IDX_FIBER_CFG0, 0);  `CHK(rd, 16'h0200)
    repeat (4) @(posedge clk);
    `CHK(signal_present, 1'b1)
    apb(1, FNP_IDX_FIBER_CFG0, 16'h0000);
    repeat (4) @(posedge clk);
    `CHK(signal_present, 1'b0)
    sigdet_pin <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(signal_present, 1'b1)
    // mid-run reset returns the written and toggled fields to reset values
    nrst <= 1'b0;
    @(posedge clk);
    `CHK(local_np_word, FNP_RST_LOCAL_NP)
    `CHK(signal_present, 1'b0)
    nrst <= 1'b1;
    @(posedge clk);
    apb(0, FNP_IDX_NEG_EXP, 0);     `CHK(rd, 16'h0004)
    apb(0, FNP_IDX_LOCAL_NP, 0);    `CHK(rd, 16'h2001)
    final_report();
  end
endmodule : fiber_autoneg_page_registers_bench
